// file: rtl/tla_limit_alarm.sv
// Limit alarm logic with hysteresis, two alarm modes and an AXI4-Lite register slave.
`timescale 1ns/100ps

module tla_limit_alarm (
   // Clock, reset and clock enable.
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic               clk_en,
   // AXI4-Lite write address channel.
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [7:0]         s_axi_awaddr,
   // AXI4-Lite write data channel.
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   // AXI4-Lite write response channel.
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   output logic [1:0]              s_axi_bresp,
   // AXI4-Lite read address channel.
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   input  wire logic [7:0]         s_axi_araddr,
   // AXI4-Lite read data channel.
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   // Conversion results and reads seen by the serial port block.
   input  tla_pkg::tla_result_s    result,
   input  wire logic               serial_read_done,
   // Alarm and interrupt outputs.
   output logic                    limit_alarm,
   output logic                    irq
);
   import tla_pkg::*;

   // Whole state of the block in one packed struct.
   typedef struct packed {
      tla_cfg_s             cfg;
      logic [15:0]          temp;
      logic                 alarm;
      logic                 comp_hi;
      logic                 comp_lo;
      logic                 pin;
      logic [TLA_IRQ_W-1:0] irq_stat;
      logic                 irq;
      logic                 aw_got;
      logic [7:0]           aw_addr;
      logic                 w_got;
      logic [31:0]          w_data;
      logic [3:0]           w_strb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
   } tla_state_s;

   tla_state_s state_ff;
   tla_state_s nxt_state;

   // Limit arithmetic in 17 bits so high minus hysteresis cannot wrap.
   logic signed [16:0] temp_x;
   logic signed [16:0] high_x;
   logic signed [16:0] low_x;
   logic signed [16:0] hyst_x;
   logic signed [16:0] high_rel;
   logic signed [16:0] low_rel;
   logic               over_high;
   logic               under_low;
   logic               take_result;
   logic               do_write;
   logic               read_done;
   logic               shdn_enter;
   logic [31:0]        rd_word;
   logic               rd_hit;

   // Signed compare of the incoming result against both limits.
   always_comb begin
      temp_x    = $signed({result.value[15], result.value});
      high_x    = $signed({state_ff.cfg.high_lim[15], state_ff.cfg.high_lim});
      low_x     = $signed({state_ff.cfg.low_lim[15], state_ff.cfg.low_lim});
      hyst_x    = $signed({6'h00, state_ff.cfg.hyst, 7'h00});
      high_rel  = high_x - hyst_x;
      low_rel   = low_x + hyst_x;
      over_high = temp_x > high_x;
      under_low = temp_x < low_x;
   end

   // Handshake outputs come straight from state so the master sees them at once.
   assign s_axi_awready = !state_ff.aw_got && !state_ff.bvalid;
   assign s_axi_wready  = !state_ff.w_got && !state_ff.bvalid;
   assign s_axi_bvalid  = state_ff.bvalid;
   assign s_axi_bresp   = state_ff.bresp;
   assign s_axi_arready = !state_ff.rvalid;
   assign s_axi_rvalid  = state_ff.rvalid;
   assign s_axi_rdata   = state_ff.rdata;
   assign s_axi_rresp   = state_ff.rresp;
   assign limit_alarm   = state_ff.pin;

   // Interrupt line is a state bit, so it leaves the block straight from a flip-flop.
   assign irq = state_ff.irq;

   // Read multiplexer; unmapped addresses answer with an error and zero data.
   // It decodes araddr straight from the pins, which is safe only because the
   // master holds the address until arready and the word is captured at that edge.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (s_axi_araddr == TLA_OFS_CTRL) begin
         rd_word[TLA_CTRL_MODE_BIT] = state_ff.cfg.comp_mode;
         rd_word[TLA_CTRL_POL_BIT]  = state_ff.cfg.pol_high;
         rd_word[TLA_CTRL_SHDN_BIT] = state_ff.cfg.shutdown;
      end else if (s_axi_araddr == TLA_OFS_HYST) begin
         rd_word[3:0] = state_ff.cfg.hyst;
      end else if (s_axi_araddr == TLA_OFS_HIGH) begin
         rd_word[15:0] = state_ff.cfg.high_lim;
      end else if (s_axi_araddr == TLA_OFS_LOW) begin
         rd_word[15:0] = state_ff.cfg.low_lim;
      end else if (s_axi_araddr == TLA_OFS_TEMP) begin
         rd_word[15:0] = state_ff.temp;
      end else if (s_axi_araddr == TLA_OFS_STAT) begin
         rd_word[0] = state_ff.alarm;
         rd_word[1] = state_ff.comp_hi;
         rd_word[2] = state_ff.comp_lo;
         rd_word[3] = state_ff.pin;
      end else if (s_axi_araddr == TLA_OFS_IRQ_STAT) begin
         rd_word[TLA_IRQ_W-1:0] = state_ff.irq_stat;
      end else if (s_axi_araddr == TLA_OFS_IRQ_MASK) begin
         rd_word[TLA_IRQ_W-1:0] = state_ff.cfg.irq_mask;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Event terms that several parts of the next-state logic share.
   always_comb begin
      do_write    = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
      read_done   = (state_ff.rvalid && s_axi_rready) || serial_read_done;
      // Results are dropped while shut down, since no conversion runs then.
      take_result = result.valid && !state_ff.cfg.shutdown;
      // Shutdown entry is a control write that sets the bit while it is clear;
      // a write that keeps shutdown set is not a new entry.
      shdn_enter  = do_write && state_ff.aw_addr == TLA_OFS_CTRL && state_ff.w_strb[0]
                    && state_ff.w_data[TLA_CTRL_SHDN_BIT] && !state_ff.cfg.shutdown;
   end

   // Next state: bus slave, configuration, alarm engine and interrupt bits.
   always_comb begin
      logic                 alarm_rise;
      logic [TLA_IRQ_W-1:0] irq_set;
      logic [TLA_IRQ_W-1:0] irq_clr;
      logic                 new_shdn;
      alarm_rise = 1'b0;
      irq_set    = '0;
      irq_clr    = '0;
      new_shdn   = state_ff.cfg.shutdown;
      nxt_state  = state_ff;

      // Write channel: address and data are taken in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_state.aw_got  = 1'b1;
         nxt_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_state.w_got  = 1'b1;
         nxt_state.w_data = s_axi_wdata;
         nxt_state.w_strb = s_axi_wstrb;
      end
      if (state_ff.bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end

      // Register write once both halves are in; answer the next cycle.
      if (do_write) begin
         nxt_state.aw_got = 1'b0;
         nxt_state.w_got  = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp  = TLA_RESP_OKAY;
         if (state_ff.aw_addr == TLA_OFS_CTRL) begin
            if (state_ff.w_strb[0]) begin
               nxt_state.cfg.comp_mode = state_ff.w_data[TLA_CTRL_MODE_BIT];
               nxt_state.cfg.pol_high  = state_ff.w_data[TLA_CTRL_POL_BIT];
               new_shdn                = state_ff.w_data[TLA_CTRL_SHDN_BIT];
               nxt_state.cfg.shutdown  = new_shdn;
            end
         end else if (state_ff.aw_addr == TLA_OFS_HYST) begin
            if (state_ff.w_strb[0]) begin
               nxt_state.cfg.hyst = state_ff.w_data[3:0];
            end
         end else if (state_ff.aw_addr == TLA_OFS_HIGH) begin
            if (state_ff.w_strb[0]) begin
               nxt_state.cfg.high_lim[7:0] = state_ff.w_data[7:0];
            end
            if (state_ff.w_strb[1]) begin
               nxt_state.cfg.high_lim[15:8] = state_ff.w_data[15:8];
            end
         end else if (state_ff.aw_addr == TLA_OFS_LOW) begin
            if (state_ff.w_strb[0]) begin
               nxt_state.cfg.low_lim[7:0] = state_ff.w_data[7:0];
            end
            if (state_ff.w_strb[1]) begin
               nxt_state.cfg.low_lim[15:8] = state_ff.w_data[15:8];
            end
         end else if (state_ff.aw_addr == TLA_OFS_IRQ_STAT) begin
            if (state_ff.w_strb[0]) begin
               irq_clr = state_ff.w_data[TLA_IRQ_W-1:0];
            end
         end else if (state_ff.aw_addr == TLA_OFS_IRQ_MASK) begin
            if (state_ff.w_strb[0]) begin
               nxt_state.cfg.irq_mask = state_ff.w_data[TLA_IRQ_W-1:0];
            end
         end else if (state_ff.aw_addr == TLA_OFS_TEMP || state_ff.aw_addr == TLA_OFS_STAT) begin
            // Read-only registers ignore writes but answer without error.
            nxt_state.bresp = TLA_RESP_OKAY;
         end else begin
            nxt_state.bresp = TLA_RESP_SLVERR;
         end
      end

      // Read channel: data is registered and held until rready.
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata  = rd_word;
         nxt_state.rresp  = rd_hit ? TLA_RESP_OKAY : TLA_RESP_SLVERR;
      end else if (state_ff.rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end

      // Interrupt mode: a completed read drops the alarm.
      if (!state_ff.cfg.comp_mode && read_done) begin
         nxt_state.alarm = 1'b0;
      end

      // Shutdown entry drops an interrupt-mode alarm but not a comparator one.
      if (shdn_enter && !state_ff.cfg.comp_mode) begin
         nxt_state.alarm = 1'b0;
      end
      // Comparator state is simply left alone across shutdown.

      // Result store and limit check in the same cycle.
      if (take_result) begin
         nxt_state.temp = result.value;
         irq_set[TLA_IRQ_RESULT_BIT] = 1'b1;
         // Comparator flags track each limit with its own release point.
         // They are kept in interrupt mode too, so a switch to comparator mode
         // shows the limit state at once instead of waiting for a new result.
         if (over_high) begin
            nxt_state.comp_hi = 1'b1;
         end else if (temp_x < high_rel) begin
            nxt_state.comp_hi = 1'b0;
         end
         if (under_low) begin
            nxt_state.comp_lo = 1'b1;
         end else if (temp_x > low_rel) begin
            nxt_state.comp_lo = 1'b0;
         end
         // A fresh out-of-limit result sets the alarm; a read clear in the
         // same cycle loses, so the event is never missed.
         if (!state_ff.cfg.comp_mode && (over_high || under_low)) begin
            nxt_state.alarm = 1'b1;
         end
      end

      // In comparator mode the alarm is the union of the two limit flags.
      if (state_ff.cfg.comp_mode) begin
         nxt_state.alarm = nxt_state.comp_hi || nxt_state.comp_lo;
      end

      alarm_rise = nxt_state.alarm && !state_ff.alarm;
      irq_set[TLA_IRQ_ALARM_BIT] = alarm_rise;

      // Sticky interrupt bits: a new event wins over a write-one clear.
      nxt_state.irq_stat = (state_ff.irq_stat & ~irq_clr) | irq_set;

      // Interrupt level from the next sticky bits and mask, so it moves with them.
      nxt_state.irq = |(nxt_state.irq_stat & nxt_state.cfg.irq_mask);

      // Pin level at the selected polarity, registered for a clean output.
      nxt_state.pin = state_ff.cfg.pol_high ? nxt_state.alarm : !nxt_state.alarm;
   end

   // State register; the clock enable freezes everything except reset while low.
   // Reset is synchronous; the control, hysteresis and limit fields, the pin and both response codes are named,
   // the blanket clear covers the rest, including the interrupt line.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff               <= '0;
         state_ff.cfg.comp_mode <= TLA_CTRL_RST[TLA_CTRL_MODE_BIT];
         state_ff.cfg.pol_high  <= TLA_CTRL_RST[TLA_CTRL_POL_BIT];
         state_ff.cfg.shutdown  <= TLA_CTRL_RST[TLA_CTRL_SHDN_BIT];
         state_ff.cfg.hyst      <= TLA_HYST_RST;
         state_ff.cfg.high_lim  <= TLA_HIGH_RST;
         state_ff.cfg.low_lim   <= TLA_LOW_RST;
         state_ff.pin           <= 1'b1;  // Inactive level for the active-low default.
         state_ff.bresp         <= TLA_RESP_OKAY;
         state_ff.rresp         <= TLA_RESP_OKAY;
      end else if (clk_en) begin
         state_ff <= nxt_state;
      end
   end

endmodule

// file: include/tla_pkg.sv
// Package of constants, types and register map for the temperature limit alarm logic.
// Operation
// - Two alarm behaviours exist, comparator mode and interrupt mode.
// - After reset the alarm runs in interrupt mode until software changes it.
// - Alarm goes active when temperature is above high limit or below low limit.
// - Comparator alarm clears only below high minus hysteresis or above low plus hysteresis.
// - In comparator mode entering shutdown leaves the alarm state unchanged.
// - In interrupt mode any completed register read clears the alarm.
// - After an interrupt clear, only a new out-of-limit result sets it again.
// - In interrupt mode entering shutdown clears the alarm to inactive.
// - Alarm active level follows a software polarity bit in both modes.
// - High limit is a 16-bit two's complement value compared signed.
// - Low limit is a 16-bit two's complement value compared signed.
// - Hysteresis is 4-bit unsigned, zero to fifteen degrees, on both limits.
package tla_pkg;

   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] TLA_OFS_CTRL      = 8'h00;
   localparam logic [7:0] TLA_OFS_HYST      = 8'h04;
   localparam logic [7:0] TLA_OFS_HIGH      = 8'h08;
   localparam logic [7:0] TLA_OFS_LOW       = 8'h0C;
   localparam logic [7:0] TLA_OFS_TEMP      = 8'h10;
   localparam logic [7:0] TLA_OFS_STAT      = 8'h14;
   localparam logic [7:0] TLA_OFS_IRQ_STAT  = 8'h18;
   localparam logic [7:0] TLA_OFS_IRQ_MASK  = 8'h1C;

   // Control register field positions.
   localparam int TLA_CTRL_MODE_BIT = 0;  // 1 = comparator mode, 0 = interrupt mode.
   localparam int TLA_CTRL_POL_BIT  = 1;  // 1 = alarm active high.
   localparam int TLA_CTRL_SHDN_BIT = 2;  // 1 = shutdown.

   // Interrupt status and mask field positions.
   localparam int TLA_IRQ_ALARM_BIT  = 0;
   localparam int TLA_IRQ_RESULT_BIT = 1;
   localparam int TLA_IRQ_W          = 2;

   // Reset values.
   localparam logic [2:0]  TLA_CTRL_RST = 3'h0;     // Interrupt mode, active low, running.
   localparam logic [3:0]  TLA_HYST_RST = 4'h5;
   localparam logic [15:0] TLA_HIGH_RST = 16'h2000;
   localparam logic [15:0] TLA_LOW_RST  = 16'h0500;

   // One degree is 128 result LSBs, so hysteresis degrees shift up by seven.
   localparam int TLA_HYST_SHIFT = 7;

   // AXI4-Lite response codes.
   localparam logic [1:0] TLA_RESP_OKAY   = 2'b00;
   localparam logic [1:0] TLA_RESP_SLVERR = 2'b10;

   // Configuration held by software.
   typedef struct packed {
      logic        comp_mode;
      logic        pol_high;
      logic        shutdown;
      logic [3:0]  hyst;
      logic [15:0] high_lim;
      logic [15:0] low_lim;
      logic [TLA_IRQ_W-1:0] irq_mask;
   } tla_cfg_s;

   // Temperature result strobe with its data.
   typedef struct packed {
      logic        valid;
      logic [15:0] value;
   } tla_result_s;

endpackage

// file: dv/tla_limit_alarm_monitor.sv
// Port-level assertion checker for the temperature limit alarm block.
`timescale 1ns/100ps

module tla_limit_alarm_monitor (
   // Clock, reset and enable.
   input wire logic           aclk,
   input wire logic           aresetn,
   input wire logic           clk_en,
   // Register bus.
   input wire logic           s_axi_awvalid,
   input wire logic           s_axi_awready,
   input wire logic [7:0]     s_axi_awaddr,
   input wire logic           s_axi_wvalid,
   input wire logic           s_axi_wready,
   input wire logic [31:0]    s_axi_wdata,
   input wire logic [3:0]     s_axi_wstrb,
   input wire logic           s_axi_bvalid,
   input wire logic           s_axi_bready,
   input wire logic [1:0]     s_axi_bresp,
   input wire logic           s_axi_arvalid,
   input wire logic           s_axi_arready,
   input wire logic [7:0]     s_axi_araddr,
   input wire logic           s_axi_rvalid,
   input wire logic           s_axi_rready,
   input wire logic [31:0]    s_axi_rdata,
   input wire logic [1:0]     s_axi_rresp,
   // Results, serial reads and outputs.
   input tla_pkg::tla_result_s result,
   input wire logic           serial_read_done,
   input wire logic           limit_alarm,
   input wire logic           irq
);
   import tla_pkg::*;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Copy of the control word taken when a write is accepted; it runs one edge ahead of
   // the block, so checks that use it wait until no write is in flight.
   logic [2:0] ctrl_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= TLA_CTRL_RST;
      end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                   && s_axi_awaddr == TLA_OFS_CTRL) begin
         ctrl_ff <= s_axi_wdata[2:0];
      end
   end
   wire bus_idle = s_axi_awready && !s_axi_awvalid;

   // Bus handshakes.
   read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");

   // Alarm behaviour.
   reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> limit_alarm && !irq &&
      !s_axi_bvalid && !s_axi_rvalid) else $error("reset state wrong");
   alarm_cause_a: assert property ($past(aresetn) && limit_alarm != $past(limit_alarm) |->
      $past(result.valid) || $past(serial_read_done) || s_axi_bvalid || $past(s_axi_bvalid)
      || ($past(s_axi_rvalid) && $past(s_axi_rready))) else $error("alarm moved alone");
   serial_clear_a: assert property (!ctrl_ff[0] && serial_read_done && !result.valid
      && bus_idle |=> limit_alarm == !ctrl_ff[1]) else $error("serial read kept alarm");
   read_clear_a: assert property (!ctrl_ff[0] && s_axi_rvalid && s_axi_rready
      && !result.valid && bus_idle |=> limit_alarm == !ctrl_ff[1])
      else $error("bus read kept alarm");

   // Clock enable low must hold the alarm pin and the interrupt line of the block.
   enable_freeze_a: assert property (!clk_en |=> $stable(limit_alarm) && $stable(irq))
      else $error("outputs moved while clock enable low");
endmodule

bind tla_limit_alarm tla_limit_alarm_monitor u_mon (.*);

// file: dv/tla_host_model.sv
// Far-side model: conversion results and completed serial register reads.
`timescale 1ns/100ps

module tla_host_model (
   // Clock.
   input wire logic           aclk,
   // Strobes into the block.
   output tla_pkg::tla_result_s result,
   output logic               serial_read_done
);
   import tla_pkg::*;

   // Quiet at time zero so the block sees no strobe during reset.
   initial begin
      result = '0;
      serial_read_done = 1'b0;
   end

   // One result pulse; the word is inverted afterwards so stale data never looks valid.
   task automatic send_result(input logic [15:0] v);
      result <= '{valid: 1'b1, value: v};
      @(posedge aclk);
      result <= '{valid: 1'b0, value: ~v};
      @(posedge aclk);
   endtask

   // One completed serial read; a spare edge keeps back-to-back calls apart.
   task automatic serial_read();
      serial_read_done <= 1'b1;
      @(posedge aclk);
      serial_read_done <= 1'b0;
      @(posedge aclk);
   endtask
endmodule

// file: dv/tla_limit_alarm_tb.sv
// Self-checking testbench for the temperature limit alarm block.
`timescale 1ns/100ps

module tla_limit_alarm_tb;
   import tla_pkg::*;

   logic                aclk = 1'b0;
   logic                aresetn = 1'b0;
   logic                clk_en = 1'b1;
   logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]          s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]         s_axi_wdata = 32'h0000_0000;
   logic [3:0]          s_axi_wstrb = 4'hF;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]          s_axi_bresp, s_axi_rresp;
   logic [31:0]         s_axi_rdata;
   tla_result_s         result;
   logic                serial_read_done, limit_alarm, irq;
   int                  fails = 0;
   int                  check_count = 0;

   // Clock at 200 MHz.
   always #2.5 aclk = ~aclk;

   tla_limit_alarm u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .result(result),
      .serial_read_done(serial_read_done), .limit_alarm(limit_alarm), .irq(irq));

   tla_host_model u_host (.aclk(aclk), .result(result), .serial_read_done(serial_read_done));

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t level %b expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask

   // Bus write; address, data and bready go up together, each valid drops when taken,
   // and the response is the one standing at the edge where bvalid meets bready.
   // Only the watchdog ends a wait; a spare edge keeps back-to-back calls apart.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] rsp = TLA_RESP_OKAY);
      logic       aw_t, w_t, done;
      logic [1:0] code;
      aw_t = 1'b0;
      w_t = 1'b0;
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         if (s_axi_awvalid && s_axi_awready) aw_t = 1'b1;
         if (s_axi_wvalid && s_axi_wready) w_t = 1'b1;
         done = s_axi_bvalid;
         code = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
      end while (!done);
      s_axi_bready <= 1'b0;
      chk_word({30'h0, code}, {30'h0, rsp});
      @(posedge aclk);
   endtask

   // Bus read checked against an expected word and response code, taken as they
   // stand at the edge where rvalid meets rready.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
      logic        ar_t, done;
      logic [31:0] got;
      logic [1:0]  code;
      ar_t = 1'b0;
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         if (s_axi_arvalid && s_axi_arready) ar_t = 1'b1;
         done = s_axi_rvalid;
         got = s_axi_rdata;
         code = s_axi_rresp;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
      end while (!done);
      s_axi_rready <= 1'b0;
      chk_word(got, exp);
      chk_word({30'h0, code}, {30'h0, rsp});
      @(posedge aclk);
   endtask

   // Pin level looked at mid-cycle, after any update from the last edge has landed.
   task automatic pin_is(input logic exp);
      @(negedge aclk);
      chk_bit(limit_alarm, exp);
      @(posedge aclk);
   endtask

   task automatic step(input logic [15:0] v, input logic exp);
      u_host.send_result(v);
      pin_is(exp);
   endtask

   task automatic report_and_stop();
      if (fails == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog well past the roughly 160 cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      report_and_stop();
   end

   // Main sequence: defaults and interrupt mode (active low), then comparator mode.
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(TLA_OFS_CTRL, 32'h0000_0000, TLA_RESP_OKAY);
      rd_chk(TLA_OFS_HYST, 32'h0000_0005, TLA_RESP_OKAY);
      rd_chk(TLA_OFS_HIGH, 32'h0000_2000, TLA_RESP_OKAY);
      rd_chk(TLA_OFS_LOW, 32'h0000_0500, TLA_RESP_OKAY);
      rd_chk(8'h20, 32'h0000_0000, TLA_RESP_SLVERR);
      axi_write(8'h20, 32'h0000_0001, TLA_RESP_SLVERR);
      pin_is(1'b1);
      axi_write(TLA_OFS_IRQ_MASK, 32'h0000_0001);
      step(16'h2001, 1'b0);
      chk_bit(irq, 1'b1);
      step(16'h2000, 1'b0);
      axi_write(TLA_OFS_IRQ_STAT, 32'h0000_0001);
      chk_bit(irq, 1'b0);
      pin_is(1'b0);
      u_host.serial_read();
      pin_is(1'b1);
      step(16'h1000, 1'b1);
      step(16'h04FF, 1'b0);
      rd_chk(TLA_OFS_TEMP, 32'h0000_04FF, TLA_RESP_OKAY);
      pin_is(1'b1);
      step(16'hFF00, 1'b0);
      axi_write(TLA_OFS_CTRL, 32'h0000_0004);
      pin_is(1'b1);
      step(16'h2001, 1'b1);
      axi_write(TLA_OFS_CTRL, 32'h0000_0000);
      axi_write(TLA_OFS_HIGH, 32'h0000_FF00);
      axi_write(TLA_OFS_LOW, 32'h0000_FE00);
      step(16'h0000, 1'b0);
      u_host.serial_read();
      axi_write(TLA_OFS_HIGH, 32'h0000_2000);
      axi_write(TLA_OFS_LOW, 32'h0000_0500);
      axi_write(TLA_OFS_HYST, 32'h0000_0002);
      step(16'h1000, 1'b1);
      // Comparator mode, active high; two degrees of hysteresis is 0x100 result steps.
      axi_write(TLA_OFS_CTRL, 32'h0000_0003);
      pin_is(1'b0);
      step(16'h2001, 1'b1);
      rd_chk(TLA_OFS_STAT, 32'h0000_000B, TLA_RESP_OKAY);
      rd_chk(TLA_OFS_IRQ_STAT, 32'h0000_0003, TLA_RESP_OKAY);
      step(16'h1F00, 1'b1);
      u_host.serial_read();
      pin_is(1'b1);
      step(16'h1EFF, 1'b0);
      step(16'h04FF, 1'b1);
      step(16'h0600, 1'b1);
      axi_write(TLA_OFS_CTRL, 32'h0000_0007);
      pin_is(1'b1);
      step(16'h1000, 1'b1);
      axi_write(TLA_OFS_CTRL, 32'h0000_0003);
      step(16'h0601, 1'b0);
      step(16'h2001, 1'b1);
      axi_write(TLA_OFS_CTRL, 32'h0000_0001);
      pin_is(1'b0);
      // Clock enable low freezes the block, so an in-range result goes unseen.
      clk_en <= 1'b0;
      u_host.send_result(16'h1000);
      pin_is(1'b0);
      clk_en <= 1'b1;
      step(16'h1000, 1'b1);
      report_and_stop();
   end
endmodule
